// ==== bench/eic_pin_model.sv ====
// Model of the two interrupt pins and of the CPU that accepts latched requests.
module eic_pin_model (
  // Clock
  input wire logic core_clk_in,
  // Requests from the bench
  input wire logic [1:0] level_in,
  input wire logic [1:0] accept_en_in,
  // Latches seen from the block
  input wire logic [1:0] irq_latch_in,
  // Pins and acceptance
  output logic [1:0] ext_pin_out,
  output logic [1:0] irq_accept_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The CPU takes a latch only while its own enable is set, so writes can be made safely.
  always_ff @(posedge core_clk_in) begin
    ext_pin_out <= level_in;
    irq_accept_out <= irq_latch_in & accept_en_in & ~irq_accept_out;
  end
endmodule : eic_pin_model

// ==== bench/tb_external_interrupt_control.sv ====
// Self-checking bench for the external interrupt block.
`include "eic_map.svh"
module tb_external_interrupt_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] gate_ix = `EIC_GATE_IDX;
  localparam logic [11:0] ctl1_ix = `EIC_CTL1_IDX;
  localparam logic [11:0] ctl2_ix = `EIC_CTL2_IDX;
  localparam logic [11:0] lat_ix = `EIC_LATCH_IDX;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] r;
  logic wreq;
  logic low_speed = 1'b0;
  logic gtick = 1'b1;
  logic lftick = 1'b0;
  logic [2:0] lfcnt = 3'h0;
  logic [1:0] lvl = 2'h0;
  logic [1:0] acc_en = 2'h0;
  logic [1:0] pins;
  logic [1:0] acc;
  logic [1:0] latch;
  logic [11:0] ix;
  logic [3:0] be = 4'h1;
  logic [5:0] gate_en;
  int err_total = 0;
  int n_tests = 0;

  initial forever #5 core_clk_in = ~core_clk_in;

  // The low-frequency clock runs at an eighth of the core clock.
  always @(posedge core_clk_in) begin
    lfcnt <= lfcnt + 3'h1;
    lftick <= (lfcnt == 3'h7);
  end

  eic_top eic_top_inst (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .low_speed_in(low_speed), .gear_tick_in(gtick), .low_freq_tick_in(lftick),
    .ext_pin_in(pins), .irq_accept_in(acc), .irq_latch_out(latch),
    .input_clock_gate_enable_out(gate_en)
  );

  eic_pin_model eic_pin_model_inst (
    .core_clk_in(core_clk_in), .level_in(lvl), .accept_en_in(acc_en),
    .irq_latch_in(latch), .ext_pin_out(pins), .irq_accept_out(acc)
  );

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic access(input logic w, input logic [11:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    adr <= {i, 2'h0};
    rd_en <= ~w;
    wr_en <= w;
    wdata <= {24'h00_0000, d};
    do begin
      @(posedge core_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n >= 50) err_total++;
  endtask : access

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    access(1'b1, i, d);
  endtask : wr

  task automatic cmp_reg(input logic [11:0] i, input logic [7:0] e);
    access(1'b0, i, 8'h00);
    n_tests++;
    if (r !== {24'h00_0000, e}) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, r, e);
    end
  endtask : cmp_reg

  task automatic cmp_latch(input logic [1:0] e);
    n_tests++;
    if (latch !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, latch, e);
    end
  endtask : cmp_latch

  // The gate output is registered at the completing edge, so look one edge later.
  task automatic cmp_gate(input logic [5:0] e);
    @(posedge core_clk_in);
    n_tests++;
    if (gate_en !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, gate_en, e);
    end
  endtask : cmp_gate

  task automatic step(input int c);
    repeat (c) @(posedge core_clk_in);
  endtask : step

  initial begin
    step(20);
    resetn_in <= 1'b1;
    cmp_reg(gate_ix, 8'h00);
    cmp_reg(ctl1_ix, 8'h00);
    cmp_reg(ctl2_ix, 8'h00);
    cmp_reg(12'h0f79, 8'h00);
    wr(ctl1_ix, 8'h0e);
    cmp_reg(ctl1_ix, 8'h00);
    be <= 4'h0;
    wr(gate_ix, 8'h3f);
    be <= 4'h1;
    cmp_reg(gate_ix, 8'h00);
    wr(gate_ix, 8'hff);
    cmp_reg(gate_ix, 8'h3f);
    cmp_gate(6'h3f);
    wr(ctl1_ix, 8'hff);
    cmp_reg(ctl1_ix, 8'h0f);
    $display("test registers finished");
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        ix = (ch == 1) ? ctl2_ix : ctl1_ix;
        wr(ix, 8'(c << 2));
        wr(lat_ix, 8'h03);
        lvl[ch] <= 1'b1;
        step(12);
        cmp_latch((c == 0 || c == 2) ? 2'(1 << ch) : 2'h0);
        if (c == 0 || c == 2) cmp_reg(ix, 8'(8'h10 | (c << 2)));
        wr(lat_ix, 8'h03);
        lvl[ch] <= 1'b0;
        step(12);
        cmp_latch((c == 1 || c == 2) ? 2'(1 << ch) : 2'h0);
        wr(lat_ix, 8'h03);
      end
    end
    $display("test edges finished");
    wr(ctl1_ix, 8'h00);
    wr(gate_ix, 8'h3d);
    cmp_gate(6'h3d);
    wr(ctl1_ix, 8'h0c);
    cmp_reg(ctl1_ix, 8'h00);
    lvl[0] <= 1'b1;
    step(20);
    cmp_latch(2'h0);
    lvl[0] <= 1'b0;
    step(5);
    wr(gate_ix, 8'h3f);
    wr(ctl1_ix, 8'h03);
    wr(lat_ix, 8'h03);
    lvl[0] <= 1'b1;
    step(30);
    cmp_latch(2'h0);
    step(60);
    cmp_latch(2'h1);
    cmp_reg(lat_ix, 8'h01);
    wr(lat_ix, 8'h03);
    lvl[0] <= 1'b0;
    step(60);
    wr(ctl1_ix, 8'h00);
    low_speed <= 1'b1;
    step(96);
    wr(lat_ix, 8'h03);
    lvl[0] <= 1'b1;
    step(40);
    cmp_latch(2'h0);
    step(160);
    cmp_latch(2'h1);
    low_speed <= 1'b0;
    step(8);
    wr(lat_ix, 8'h03);
    $display("test intervals finished");
    wr(ctl2_ix, 8'h00);
    wr(lat_ix, 8'h03);
    acc_en <= 2'h2;
    lvl[1] <= 1'b1;
    step(15);
    cmp_latch(2'h0);
    cmp_reg(ctl2_ix, 8'h10);
    $display("test accept finished");
    conclude();
  end

  // The tests need well under 3000 cycles; a hang is cut off long after that.
  initial begin
    step(20000);
    err_total++;
    conclude();
  end
endmodule : tb_external_interrupt_control

// ==== verilog/eic_chan.sv ====
// One external interrupt input: sampling divider, noise filter and edge detector.
`include "eic_map.svh"

module eic_chan (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Control
  input wire logic gate_en_in,
  input wire logic low_speed_in,
  input wire eic_pkg::eic_ctl_t ctl_in,
  // Timing enables
  input wire logic gear_tick_in,
  input wire logic fs4_tick_in,
  // Synchronised pin level
  input wire logic pin_in,
  // Results
  output logic filt_out,
  output logic req_out
);

  eic_pkg::eic_chan_state_t q, d;
  logic [3:0] last;
  logic tick;
  logic sample;
  logic [2:0] shifted;

  always_comb begin
    d = q;
    d.req = 1'b0;
    tick = low_speed_in ? fs4_tick_in : gear_tick_in;
    if (low_speed_in) begin
      last = `EIC_DIV1_LAST;
    end else begin
      case (ctl_in.filter_interval)
        eic_pkg::EIC_NC_DIV1: last = `EIC_DIV1_LAST;
        eic_pkg::EIC_NC_DIV4: last = `EIC_DIV4_LAST;
        eic_pkg::EIC_NC_DIV8: last = `EIC_DIV8_LAST;
        eic_pkg::EIC_NC_DIV16: last = `EIC_DIV16_LAST;
        default: last = `EIC_DIV1_LAST;
      endcase
    end
    // A gated input holds its divider, samples and filtered level, as if its clock had stopped, and raises no request.
    sample = gate_en_in && tick && (q.div_cnt >= last);
    shifted = {q.samples[1:0], pin_in};
    if (gate_en_in && tick) begin
      d.div_cnt = sample ? 4'h0 : 4'(q.div_cnt + 4'h1);
    end
    if (sample) begin
      d.samples = shifted;
      if (shifted == 3'h7) begin
        d.filt = 1'b1;
      end else if (shifted == 3'h0) begin
        d.filt = 1'b0;
      end
    end
    // Only the filtered level feeds the edge detector.
    if (d.filt != q.filt) begin
      case (ctl_in.edge_select)
        eic_pkg::EIC_ES_RISE: d.req = d.filt;
        eic_pkg::EIC_ES_FALL: d.req = !d.filt;
        eic_pkg::EIC_ES_BOTH: d.req = 1'b1;
        default: d.req = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign filt_out = q.filt;
  assign req_out = q.req;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_falling_edge_req:
    assert property ((ctl_in.edge_select == eic_pkg::EIC_ES_FALL) && q.filt && !d.filt
      |=> req_out)
    else $error("Falling filtered edge gave no request.");

  a_reserved_no_req:
    assert property ((ctl_in.edge_select == eic_pkg::EIC_ES_RSVD) |=> !req_out
      || ($past(ctl_in.edge_select) != eic_pkg::EIC_ES_RSVD))
    else $error("Reserved edge code raised a request.");

  a_gated_frozen:
    assert property (!gate_en_in |=> $stable({q.div_cnt, q.samples, q.filt}) && !req_out)
    else $error("Gated channel changed state.");

  a_slow_rate:
    assert property (gate_en_in && low_speed_in && fs4_tick_in |-> sample)
    else $error("Slow mode skipped a low-frequency sample.");

  a_div16_interval:
    assert property (sample && !low_speed_in
      && (ctl_in.filter_interval == eic_pkg::EIC_NC_DIV16) |-> q.div_cnt == 4'hf)
    else $error("Divide-by-16 interval sampled early.");

  a_filter_stable:
    assert property ($changed(filt_out) |-> q.samples == {3{filt_out}})
    else $error("Filter passed a level without stable samples.");

endmodule : eic_chan

// ==== verilog/eic_map.svh ====
// Register offsets, field positions, reset values and counts of the external interrupt block.
`ifndef EIC_MAP_SVH
`define EIC_MAP_SVH

// Register indices; the bus byte address is four times the index.
`define EIC_GATE_IDX 12'h0f77
`define EIC_CTL1_IDX 12'h0fd8
`define EIC_CTL2_IDX 12'h0fd9
`define EIC_LATCH_IDX 12'h0f78

// Bus geometry.
`define EIC_ADDR_W 14
`define EIC_DATA_W 32

// Field positions inside the control registers.
`define EIC_LVL_BIT 4
`define EIC_ES_LSB 2
`define EIC_NC_LSB 0

// Reset values.
`define EIC_GATE_RST 6'h00
`define EIC_CTL_RST 4'h0

// Filter and divider counts.
`define EIC_FILT_SAMPLES 3
`define EIC_FS_DIV_LAST 2'h3
`define EIC_DIV1_LAST 4'h0
`define EIC_DIV4_LAST 4'h3
`define EIC_DIV8_LAST 4'h7
`define EIC_DIV16_LAST 4'hf

`endif

// ==== verilog/eic_pkg.sv ====
// Types shared by the external interrupt block.
package eic_pkg;

  typedef enum logic [1:0] {
    EIC_ES_RISE = 2'h0,
    EIC_ES_FALL = 2'h1,
    EIC_ES_BOTH = 2'h2,
    EIC_ES_RSVD = 2'h3
  } eic_edge_t;

  typedef enum logic [1:0] {
    EIC_NC_DIV1 = 2'h0,
    EIC_NC_DIV4 = 2'h1,
    EIC_NC_DIV8 = 2'h2,
    EIC_NC_DIV16 = 2'h3
  } eic_interval_t;

  typedef struct packed {
    eic_edge_t edge_select;
    eic_interval_t filter_interval;
  } eic_ctl_t;

  typedef struct packed {
    logic [3:0] div_cnt;
    logic [2:0] samples;
    logic filt;
    logic req;
  } eic_chan_state_t;

  typedef struct packed {
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] fs_cnt;
    logic fs4_tick;
    logic [5:0] gate;
    eic_ctl_t ctl1;
    eic_ctl_t ctl2;
    logic [1:0] lvl;
    logic [1:0] latch;
    logic waitreq;
    logic [31:0] rdata;
  } eic_top_state_t;

endpackage : eic_pkg

// ==== verilog/eic_top.sv ====
// Avalon-MM register block with clock gating, control and latches for external interrupts.
//
// Our own choice: the Avalon-MM slave port.
`include "eic_map.svh"

module eic_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [`EIC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [`EIC_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [`EIC_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Operating mode and timing enables from the clock generator
  input wire logic low_speed_in,
  input wire logic gear_tick_in,
  input wire logic low_freq_tick_in,
  // External interrupt pins 1 and 2
  input wire logic [1:0] ext_pin_in,
  // Interrupt acceptance from the CPU
  input wire logic [1:0] irq_accept_in,
  // Interrupt latches and clock-gate enables
  output logic [1:0] irq_latch_out,
  output logic [5:0] input_clock_gate_enable_out
);

  eic_pkg::eic_top_state_t q, d;
  logic [1:0] filt;
  logic [1:0] req;
  logic [11:0] index;
  logic aligned;
  logic write_done;
  logic lane0;
  logic [7:0] ctl1_view;
  logic [7:0] ctl2_view;

  // The control bits drive both channels directly from their registers.
  eic_chan u_chan1 (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .gate_en_in(q.gate[1]),
    .low_speed_in(low_speed_in),
    .ctl_in(q.ctl1),
    .gear_tick_in(gear_tick_in),
    .fs4_tick_in(q.fs4_tick),
    .pin_in(q.pin_sync[0]),
    .filt_out(filt[0]),
    .req_out(req[0])
  );

  eic_chan u_chan2 (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .gate_en_in(q.gate[2]),
    .low_speed_in(low_speed_in),
    .ctl_in(q.ctl2),
    .gear_tick_in(gear_tick_in),
    .fs4_tick_in(q.fs4_tick),
    .pin_in(q.pin_sync[1]),
    .filt_out(filt[1]),
    .req_out(req[1])
  );

  always_comb begin
    d = q;
    index = avs_address_in[`EIC_ADDR_W-1:2];
    aligned = (avs_address_in[1:0] == 2'h0);
    lane0 = avs_byteenable_in[0];
    ctl1_view = {3'h0, q.lvl[0], q.ctl1};
    ctl2_view = {3'h0, q.lvl[1], q.ctl2};

    // Pins cross into the core clock through two flip-flops.
    d.pin_meta = ext_pin_in;
    d.pin_sync = q.pin_meta;

    // Quarter of the low-frequency clock for the slow modes.
    d.fs4_tick = 1'b0;
    if (low_freq_tick_in) begin
      d.fs_cnt = 2'(q.fs_cnt + 2'h1);
      d.fs4_tick = (q.fs_cnt == `EIC_FS_DIV_LAST);
    end

    // The slave holds waitrequest high, drops it for one cycle once the
    // request is seen, and completes on the edge where it is low.
    write_done = 1'b0;
    if (q.waitreq) begin
      if (avs_read_in || avs_write_in) begin
        d.waitreq = 1'b0;
        d.rdata = 32'h0000_0000;
        if (avs_read_in && aligned) begin
          case (index)
            `EIC_GATE_IDX: d.rdata = {26'h00_0000, q.gate};
            `EIC_CTL1_IDX: d.rdata = {24'h00_0000, ctl1_view};
            `EIC_CTL2_IDX: d.rdata = {24'h00_0000, ctl2_view};
            `EIC_LATCH_IDX: d.rdata = {30'h000_0000, q.latch};
            default: d.rdata = 32'h0000_0000;
          endcase
        end
      end
    end else begin
      d.waitreq = 1'b1;
      write_done = avs_write_in && aligned && lane0;
    end

    if (write_done) begin
      case (index)
        `EIC_GATE_IDX: d.gate = avs_writedata_in[5:0];
        `EIC_CTL1_IDX: begin
          if (q.gate[1]) begin
            d.ctl1 = avs_writedata_in[3:0];
          end
        end
        `EIC_CTL2_IDX: begin
          if (q.gate[2]) begin
            d.ctl2 = avs_writedata_in[3:0];
          end
        end
        `EIC_LATCH_IDX: d.latch = q.latch & ~avs_writedata_in[1:0];
        default: d.latch = d.latch;
      endcase
    end

    // Acceptance clears a latch; a request in the same cycle wins.
    d.latch = d.latch & ~irq_accept_in;
    for (int i = 0; i < 2; i++) begin
      if (req[i]) begin
        d.latch[i] = 1'b1;
        d.lvl[i] = filt[i];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
      q.waitreq <= 1'b1;
      q.gate <= `EIC_GATE_RST;
      q.ctl1 <= `EIC_CTL_RST;
      q.ctl2 <= `EIC_CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = q.waitreq;
  assign irq_latch_out = q.latch;
  assign input_clock_gate_enable_out = q.gate;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_gate_write_lands:
    assert property (avs_write_in && !q.waitreq && aligned && lane0
      && (index == `EIC_GATE_IDX) |=> q.gate == $past(avs_writedata_in[5:0]))
    else $error("Clock-gate write did not land.");

  a_gate_high_zero:
    assert property (avs_read_in && !q.waitreq && (index == `EIC_GATE_IDX)
      |-> avs_readdata_out[31:6] == 26'h00_0000)
    else $error("Clock-gate upper bits read nonzero.");

  a_ctl_write_blocked:
    assert property (avs_write_in && !q.waitreq && (index == `EIC_CTL1_IDX) && !q.gate[1]
      |=> $stable(q.ctl1))
    else $error("Control write took effect on a gated input.");

  a_ctl_high_zero:
    assert property (avs_read_in && !q.waitreq
      && ((index == `EIC_CTL1_IDX) || (index == `EIC_CTL2_IDX))
      |-> avs_readdata_out[7:5] == 3'h0)
    else $error("Control upper bits read nonzero.");

  a_req_sets_latch:
    assert property (req[0] |=> irq_latch_out[0] ##0 q.lvl[0] == $past(filt[0]))
    else $error("Request did not set latch and capture level.");

  a_latch_holds:
    assert property (irq_latch_out[1] && !irq_accept_in[1] && !write_done
      |=> irq_latch_out[1])
    else $error("Latch dropped without accept or clear.");

  a_wait_one_cycle:
    assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("Waitrequest stayed low for more than one cycle.");

  a_slow_div_four:
    assert property (q.fs4_tick |-> $past(low_freq_tick_in) && $past(q.fs_cnt) == 2'h3)
    else $error("Quarter-rate tick off its divider.");

endmodule : eic_top
